// ===== rtl/pifb_edge_det.v
`timescale 1ns/1ns
// ----------------------------------------
// Per-bit edge detector for level sources
// ----------------------------------------
module pifb_edge_det #(
  parameter WIDTH = 4
) (
  input  wire             i_sys_clk,
  input  wire             i_rst,
  input  wire             i_clk_en,
  input  wire [WIDTH-1:0] i_level,
  output wire [WIDTH-1:0] o_rise,
  output wire [WIDTH-1:0] o_fall
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg prev_ff;
      // Previous level; reset low so a source already high counts as an entry
      always @(posedge i_sys_clk) begin
        if (i_rst) begin
          prev_ff <= 1'b0;
        end else if (i_clk_en) begin
          prev_ff <= i_level[gi];
        end
      end
      // Edges are qualified by the enable so a frozen block sees no event
      assign o_rise[gi] = i_clk_en & i_level[gi] & ~prev_ff;
      assign o_fall[gi] = i_clk_en & ~i_level[gi] & prev_ff;
    end
  endgenerate

endmodule

// ===== rtl/pifb_flag_bank.v
// What this block does
// RULE_01: Each flag is set by its source event regardless of any mask or global enable bit.
// RULE_02: Software should clear a source's flag before it unmasks that source, or a stale event interrupts at once.
// RULE_03: Bits 7 and 6 set when wave generator B or A enters shutdown and read 0 otherwise or once cleared.
// RULE_04: Bit 5 sets when the fifth timer's gate goes inactive and stays clear while it has not.
// RULE_05: Bit 4 sets on a fifth timer overflow and only software clears it.
// RULE_06: In capture mode a channel flag sets on a capture and stays until software clears it.
// RULE_07: In compare mode a channel flag sets on a compare match and stays until software clears it.
// RULE_08: In PWM mode a channel flag sets on each trailing edge of the PWM output and stays until cleared.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "pifb_regs.vh"

module pifb_flag_bank #(
  parameter NUM_CH = 4
) (
  input  wire              i_sys_clk,
  input  wire              i_rst,
  input  wire              i_clk_en,
  // Wishbone classic slave
  input  wire              i_wb_cyc,
  input  wire              i_wb_stb,
  input  wire              i_wb_we,
  input  wire [3:0]        i_wb_adr,
  input  wire [3:0]        i_wb_sel,
  input  wire [31:0]       i_wb_dat,
  output reg  [31:0]       o_wb_dat,
  output reg               o_wb_ack,
  // Event sources, all on the system clock
  input  wire              i_wavegen_a_shutdown,
  input  wire              i_wavegen_b_shutdown,
  input  wire              i_timer_five_gate,
  input  wire              i_timer_five_ovf,
  input  wire [NUM_CH-1:0] i_capcmp_capture,
  input  wire [NUM_CH-1:0] i_capcmp_match,
  input  wire [NUM_CH-1:0] i_capcmp_pwm_out,
  // Interrupt and flag view
  output wire              o_irq,
  output wire [7:0]        o_peripheral_request_flags_four
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [7:0]          flags_ff;
  reg  [7:0]          nxt_flags;
  reg  [7:0]          mask_ff;
  reg  [2*NUM_CH-1:0] mode_ff;
  reg  [7:0]          set_vec;
  reg  [7:0]          clr_vec;
  reg  [31:0]         rd_word;

  wire [NUM_CH-1:0]   ch_event;
  wire [1:0]          wg_rise;
  wire                gate_fall;
  wire [NUM_CH-1:0]   pwm_fall;

  wire                wb_req;
  wire                wb_wr;
  wire                wr_flags;
  wire                wr_mask;
  wire                wr_mode;
  wire [7:0]          live_vec;

  // ----------------------------------------
  // Edge detection of level sources
  // ----------------------------------------
  // One detector per group keeps shutdown, gate and PWM edges aligned
  pifb_edge_det #(.WIDTH(2)) u_wg_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_level   ({i_wavegen_b_shutdown, i_wavegen_a_shutdown}),
    .o_rise    (wg_rise),
    .o_fall    ()
  );

  // Gate edge: only the closing edge matters, opening the gate is ignored
  pifb_edge_det #(.WIDTH(1)) u_gate_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_level   (i_timer_five_gate),
    .o_rise    (),
    .o_fall    (gate_fall)
  );

  // Trailing edge of each PWM output; leading edges are not events
  pifb_edge_det #(.WIDTH(NUM_CH)) u_pwm_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_level   (i_capcmp_pwm_out),
    .o_rise    (),
    .o_fall    (pwm_fall)
  );

  // ----------------------------------------
  // Channel event selection by mode
  // ----------------------------------------
  // Mode steers which source counts; an off channel never raises its flag
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc = gc + 1) begin : g_ch
      reg ch_hit;
      always @* begin
        case (mode_ff[2*gc +: 2])
          `PIFB_MODE_CAPTURE: ch_hit = i_capcmp_capture[gc]; // RULE_06
          `PIFB_MODE_COMPARE: ch_hit = i_capcmp_match[gc];   // RULE_07
          `PIFB_MODE_PWM:     ch_hit = pwm_fall[gc];         // RULE_08
          default:            ch_hit = 1'b0;
        endcase
      end
      assign ch_event[gc] = ch_hit;
    end
  endgenerate

  // ----------------------------------------
  // Hardware set vector
  // ----------------------------------------
  // No mask term here: flags record events even while masked
  always @* begin
    set_vec = 8'h00;
    set_vec[`PIFB_BIT_WAVEGEN_B] = wg_rise[1];                   // RULE_03
    set_vec[`PIFB_BIT_WAVEGEN_A] = wg_rise[0];                   // RULE_03
    set_vec[`PIFB_BIT_TMR5_GATE] = gate_fall;                    // RULE_04
    set_vec[`PIFB_BIT_TMR5_OVF]  = i_clk_en & i_timer_five_ovf;  // RULE_05
    set_vec[`PIFB_CAPCMP_LSB +: NUM_CH] = ch_event & {NUM_CH{i_clk_en}};
  end

  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // Registers are eight bits wide so only lane 0 carries write data
  assign wb_wr  = wb_req & i_wb_we & i_wb_sel[0];

  // One strobe per writable register keeps each write path easy to follow
  assign wr_flags = wb_wr & (i_wb_adr == `PIFB_ADR_FLAGS);
  assign wr_mask  = wb_wr & (i_wb_adr == `PIFB_ADR_MASK);
  assign wr_mode  = wb_wr & (i_wb_adr == `PIFB_ADR_MODE);

  // Write-one-to-clear on the flag register only
  always @* begin
    clr_vec = 8'h00;
    if (wr_flags) begin
      clr_vec = i_wb_dat[7:0];
    end
  end

  // Set wins over clear so an event in the clearing cycle survives
  always @* begin
    nxt_flags = (flags_ff & ~clr_vec) | set_vec; // RULE_01
  end

  // ----------------------------------------
  // Flag, mask and mode registers
  // ----------------------------------------
  // Flags move only on enabled edges; a frozen block neither sets nor clears
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      flags_ff <= `PIFB_FLAGS_RST;
    end else if (i_clk_en) begin
      flags_ff <= nxt_flags; // RULE_05
    end
  end

  // Mask is plain read/write storage and never touches the flags
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      mask_ff <= `PIFB_MASK_RST;
    end else if (i_clk_en && wr_mask) begin
      mask_ff <= i_wb_dat[7:0];
    end
  end

  // A mode change applies from the next edge; an event in the same cycle uses the old mode
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_ff <= `PIFB_MODE_RST;
    end else if (i_clk_en && wr_mode) begin
      mode_ff <= i_wb_dat[2*NUM_CH-1:0];
    end
  end

  // Live levels of the level sources, useful to see a generator still in shutdown
  assign live_vec = {i_wavegen_b_shutdown, i_wavegen_a_shutdown, i_timer_five_gate, 1'b0, i_capcmp_pwm_out};

  // ----------------------------------------
  // Wishbone answer
  // ----------------------------------------
  // Narrow registers are zero-extended so the upper lanes always read clean
  always @* begin
    rd_word = `PIFB_ZERO_WORD;
    case (i_wb_adr)
      `PIFB_ADR_FLAGS: rd_word[7:0]          = flags_ff;
      `PIFB_ADR_MASK:  rd_word[7:0]          = mask_ff;
      `PIFB_ADR_MODE:  rd_word[2*NUM_CH-1:0] = mode_ff;
      `PIFB_ADR_LIVE:  rd_word[7:0]          = live_vec;
      default:         rd_word               = `PIFB_ZERO_WORD;
    endcase
  end

  // Registered ack one cycle after the request; unmapped reads return zero
  // Ack high blocks a second take of the same request in the answer cycle
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `PIFB_ZERO_WORD;
    end else if (i_clk_en) begin
      o_wb_ack <= wb_req;
      if (wb_req) begin
        o_wb_dat <= rd_word;
      end
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Level output; a stale flag unmasked later fires at once, hence clear first
  assign o_irq = |(flags_ff & mask_ff); // RULE_02
  // Flag pins mirror the register so the core sees what the bus reads
  assign o_peripheral_request_flags_four = flags_ff;

endmodule

// ===== rtl/pifb_regs.vh
`ifndef PIFB_REGS_VH
`define PIFB_REGS_VH

// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define PIFB_ADR_FLAGS      4'h0
`define PIFB_ADR_MASK       4'h4
`define PIFB_ADR_MODE       4'h8
`define PIFB_ADR_LIVE       4'hC

// ----------------------------------------
// Field positions in the flag register
// ----------------------------------------
`define PIFB_BIT_WAVEGEN_B  7
`define PIFB_BIT_WAVEGEN_A  6
`define PIFB_BIT_TMR5_GATE  5
`define PIFB_BIT_TMR5_OVF   4
`define PIFB_CAPCMP_LSB     0

// ----------------------------------------
// Reset values and channel modes
// ----------------------------------------
`define PIFB_FLAGS_RST      8'h00
`define PIFB_MASK_RST       8'h00
`define PIFB_MODE_RST       8'h00
`define PIFB_MODE_OFF       2'h0
`define PIFB_MODE_CAPTURE   2'h1
`define PIFB_MODE_COMPARE   2'h2
`define PIFB_MODE_PWM       2'h3
`define PIFB_ZERO_WORD      32'h0000_0000

`endif

// ===== test/pifb_flag_bank_properties.sv
`timescale 1ns/1ns
// ----------------
// Flag bank checks
// ----------------
module pifb_flag_bank_chk #(
  parameter NUM_CH = 4
) (
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire        i_clk_en,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [3:0]  i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire        i_wavegen_a_shutdown,
  input wire        i_wavegen_b_shutdown,
  input wire        i_timer_five_gate,
  input wire        i_timer_five_ovf,
  input wire [7:0]  o_peripheral_request_flags_four
);
  // Bits a flag write might clear; kept loose so no legal clear is flagged
  wire [7:0] f    = o_peripheral_request_flags_four;
  wire       wr0  = i_wb_stb && i_wb_we && (i_wb_adr == 4'h0);
  wire [7:0] keep = f & ~(wr0 ? i_wb_dat[7:0] : 8'h00);
  // Source levels as last taken on an enabled edge; low after reset, so a level high at release is an entry
  reg  [2:0] seen_ff;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      seen_ff <= 3'b000;
    end else if (i_clk_en) begin
      seen_ff <= {i_wavegen_b_shutdown, i_wavegen_a_shutdown, i_timer_five_gate};
    end
  end
  wire       gate_close = i_clk_en && seen_ff[0] && !i_timer_five_gate;
  wire       wga_enter  = i_clk_en && !seen_ff[1] && i_wavegen_a_shutdown;
  wire       wgb_enter  = i_clk_en && !seen_ff[2] && i_wavegen_b_shutdown;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ovf_sets_flag_a: assert property (i_clk_en && i_timer_five_ovf |=> f[4])
    else $error("overflow flag not set");
  ovf_quiet_a: assert property (!f[4] && !i_timer_five_ovf |=> !f[4])
    else $error("overflow flag set without cause");
  gate_close_flag_a: assert property (gate_close |=> f[5])
    else $error("gate flag not set");
  gate_quiet_a: assert property (!f[5] && !gate_close |=> !f[5])
    else $error("gate flag set without cause");
  wga_shutdown_a: assert property (wga_enter |=> f[6])
    else $error("wavegen a flag not set");
  wga_quiet_a: assert property (!f[6] && !wga_enter |=> !f[6])
    else $error("wavegen a flag set without cause");
  wgb_shutdown_a: assert property (wgb_enter |=> f[7])
    else $error("wavegen b flag not set");
  wgb_quiet_a: assert property (!f[7] && !wgb_enter |=> !f[7])
    else $error("wavegen b flag set without cause");
  flags_sticky_a: assert property (1 |=> (f & $past(keep)) == $past(keep))
    else $error("flag dropped without a clear");
endmodule

bind pifb_flag_bank pifb_flag_bank_chk #(.NUM_CH(NUM_CH)) chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_clk_en(i_clk_en), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .i_wavegen_a_shutdown(i_wavegen_a_shutdown), .i_wavegen_b_shutdown(i_wavegen_b_shutdown),
  .i_timer_five_gate(i_timer_five_gate), .i_timer_five_ovf(i_timer_five_ovf),
  .o_peripheral_request_flags_four(o_peripheral_request_flags_four));

// ===== test/pifb_flag_bank_tb.sv
`timescale 1ns/1ns
module pifb_flag_bank_tb;
  // ----------------
  // Stimulus and DUT
  // ----------------
  logic        clk = 0, rst = 1, en = 1, cyc = 0, stb = 0, we = 0, wga = 0, wgb = 0, gate = 0, ovf = 0;
  logic [3:0]  adr = 4'h0, sel = 4'hF, cap = 4'h0, mat = 4'h0, pwm = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rd;
  wire  [31:0] o_dat;
  wire  [7:0]  flags;
  wire         ack, irq;
  int          mismatches = 0, compares = 0, cycles = 0;

  pifb_flag_bank #(.NUM_CH(4)) DUT (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(en), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(o_dat),
    .o_wb_ack(ack), .i_wavegen_a_shutdown(wga), .i_wavegen_b_shutdown(wgb), .i_timer_five_gate(gate),
    .i_timer_five_ovf(ovf), .i_capcmp_capture(cap), .i_capcmp_match(mat), .i_capcmp_pwm_out(pwm),
    .o_irq(irq), .o_peripheral_request_flags_four(flags));

  // 25 MHz clock
  initial forever #20 clk = ~clk;

  // Cut a hang short; the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  // ---------
  // Helpers
  // ---------
  task conclude();
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task check(input string n, input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  // One classic cycle; the master holds everything until ack
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rd = o_dat;
    cyc <= 0;
    stb <= 0;
  endtask

  task rdchk(input string n, input logic [3:0] a, input logic [7:0] e);
    wb(0, a, 8'h00, 4'hF);
    check(n, rd[7:0], e);
  endtask

  // ---------
  // Sequence
  // ---------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rdchk("flags", 4'h0, 8'h00);
    rdchk("mask", 4'h4, 8'h00);
    rdchk("unmapped", 4'h1, 8'h00);
    // A frozen block loses an overflow pulse
    @(posedge clk);
    en <= 0;
    ovf <= 1;
    @(posedge clk);
    ovf <= 0;
    en <= 1;
    rdchk("frozen", 4'h0, 8'h00);
    // Overflow lands while masked, so it waits silently
    @(posedge clk);
    ovf <= 1;
    @(posedge clk);
    ovf <= 0;
    rdchk("ovf", 4'h0, 8'h10);
    check("flag pins", flags, 8'h10);
    check("irq off", {7'h00, irq}, 8'h00);
    wb(1, 4'h4, 8'hF0, 4'hE);
    rdchk("mask sel", 4'h4, 8'h00);
    wb(1, 4'h4, 8'hF0, 4'hF);
    check("irq on", {7'h00, irq}, 8'h01);
    wb(1, 4'h0, 8'h10, 4'hF);
    check("irq clr", {7'h00, irq}, 8'h00);
    // Overflow in the very cycle its clear lands: the set must win
    fork
      wb(1, 4'h0, 8'h10, 4'hF);
      begin
        @(posedge clk);
        ovf <= 1;
        @(posedge clk);
        ovf <= 0;
      end
    join
    rdchk("set wins", 4'h0, 8'h10);
    wb(1, 4'h0, 8'h10, 4'hF);
    // Shutdown entry and gate close; gate opening must not set
    @(posedge clk);
    wga <= 1;
    gate <= 1;
    @(posedge clk);
    wgb <= 1;
    rdchk("wavegen", 4'h0, 8'hC0);
    wb(1, 4'h0, 8'hC0, 4'hF);
    rdchk("held shut", 4'h0, 8'h00);
    rdchk("live", 4'hC, 8'hE0);
    gate <= 0;
    wga <= 0;
    rdchk("gate", 4'h0, 8'h20);
    wb(1, 4'h0, 8'hFF, 4'hF);
    wb(1, 4'h4, 8'h0F, 4'hF);
    // Every channel mode, all channels at once for capture and PWM, channels 0 and 2 for match
    for (int m = 0; m < 4; m++) begin
      wb(1, 4'h8, {4{m[1:0]}}, 4'hF);
      rdchk("mode", 4'h8, {4{m[1:0]}});
      @(posedge clk);
      cap <= 4'hF;
      pwm <= 4'hF;
      @(posedge clk);
      cap <= 4'h0;
      rdchk("capture", 4'h0, m == 1 ? 8'h0F : 8'h00);
      check("irq cap", {7'h00, irq}, m == 1 ? 8'h01 : 8'h00);
      wb(1, 4'h0, 8'hFF, 4'hF);
      mat <= 4'h5;
      @(posedge clk);
      mat <= 4'h0;
      rdchk("match", 4'h0, m == 2 ? 8'h05 : 8'h00);
      wb(1, 4'h0, 8'hFF, 4'hF);
      pwm <= 4'h0;
      rdchk("pwm", 4'h0, m == 3 ? 8'h0F : 8'h00);
      wb(1, 4'h0, 8'hFF, 4'hF);
    end
    conclude();
  end
endmodule
